// ==== diag_record_consts.svh ====
`ifndef DIAG_RECORD_CONSTS_SVH
`define DIAG_RECORD_CONSTS_SVH

// fixed record contents
`define CHANNEL_KIND_VAL     8'h72
`define DIAG_BITS_VAL        8'h08
`define CHANNEL_COUNT_VAL    8'h04
`define SHORT_BIT_POS        3

// record byte positions
`define REC_CHANNEL_KIND     5'h04
`define REC_DIAG_BITS        5'h05
`define REC_CHANNEL_COUNT    5'h06
`define REC_ERR_SUMMARY      5'h07
`define REC_DETAIL_FIRST     5'h08
`define REC_DETAIL_LAST      5'h0B
`define REC_TS_FIRST         5'h10
`define REC_TS_LAST          5'h13

// dictionary index areas
`define AREA_SYS_LO          16'h1000
`define AREA_SYS_HI          16'h6FFF
`define AREA_IO_LO           16'h7000
`define AREA_IO_HI           16'h7FFF
`define AREA_AXIS_LO         16'h8000
`define AREA_AXIS_HI         16'h8FFF

// implemented objects and their subindex counts
`define OBJ_SYSTEM           16'h6100
`define OBJ_DOUT             16'h7200
`define OBJ_CONTROL          16'h8100
`define OBJ_HOMING           16'h8300
`define SYSTEM_SUBS          32'h0000_0001
`define DOUT_SUBS            32'h0000_0002
`define CONTROL_SUBS         32'h0000_0002
`define HOMING_SUBS          32'h0000_0001

// reset values
`define CTRL_WORD_RST        16'h0000
`define OUT_REQ_RST          4'h0
`define HOMING_RST           32'h0000_0000
`define MSG_TIMEOUT_RST      16'h0000

// microsecond ticker timing
`define TICK_NS              1000
`define CLK_NS               8
`define TICK_CYCLES          (`TICK_NS / `CLK_NS)

`endif

// ==== diag_record_pkg.sv ====
package diag_record_pkg;

  typedef enum logic [1:0] {
    ACYC_OK,
    ACYC_NO_OBJECT,
    ACYC_READ_ONLY,
    ACYC_LOCKED
  } acyc_status_e;

  typedef enum logic [1:0] {
    AREA_NONE,
    AREA_SYSTEM,
    AREA_IO,
    AREA_AXIS
  } obj_area_e;

  typedef logic [7:0] rec_byte_t;

endpackage

// ==== diag_record_and_object_access.sv ====
// How it works
// - channel kind byte reads 72h, digital output, bit 7 fixed zero.
// - diagnostic bits per channel byte is constant 08h.
// - channel count byte is constant 04h.
// - summary bits 0..3 flag errors on outputs one to four.
// - each channel detail byte uses bit 3 for short circuit only.
// - microsecond ticker is captured as timestamp when a fault arises.
// - spare header bytes and channels four to seven carry nothing.
// - objects are selected by a unique index and subindex pair.
// - index areas: system 1000h-6FFFh, io 7000h-7FFFh, axis 8000h-8FFFh.
// - subindex 0 of every object returns its subindex count.
// - main objects travel through the cyclic io image.
// - every acyclic dictionary access gets an acknowledge.
// - cyclic object placement is fixed, not configurable.
// - cyclic exchange overwrites acyclic writes to mapped objects.
// - incoming and going events on faults; lamp lit while any fault.
// - writes only in switch-on-disabled, except always-writable objects.
`timescale 1ns/1ps
`include "diag_record_consts.svh"

module diag_record_and_object_access (
  // clock, reset, enable
  input  wire logic                         ref_clk_i,
  input  wire logic                         rst_i,
  input  wire logic                         ce_i,
  // fault sources
  input  wire logic [3:0]                   out_err_i,
  input  wire logic [3:0]                   short_i,
  // diagnostic record read
  input  wire logic                         rec_rd_i,
  input  wire logic [4:0]                   rec_addr_i,
  output logic                              rec_valid_o,
  output logic [7:0]                        rec_data_o,
  // acyclic channel
  input  wire logic                         acyc_req_i,
  input  wire logic                         acyc_wr_i,
  input  wire logic [15:0]                  acyc_index_i,
  input  wire logic [7:0]                   acyc_sub_i,
  input  wire logic [31:0]                  acyc_wdata_i,
  output logic                              acyc_ack_o,
  output diag_record_pkg::acyc_status_e     acyc_status_o,
  output logic [31:0]                       acyc_rdata_o,
  // cyclic io image
  input  wire logic                         cyc_strobe_i,
  input  wire logic [15:0]                  cyc_ctrl_word_i,
  input  wire logic [3:0]                   cyc_out_req_i,
  output logic [15:0]                       cyc_in_status_o,
  output logic [3:0]                        cyc_in_outs_o,
  // drive side
  input  wire logic [15:0]                  status_word_i,
  input  wire logic [3:0]                   out_actual_i,
  input  wire logic                         drive_sod_i,
  output logic [15:0]                       ctrl_word_o,
  output logic [3:0]                        out_req_o,
  output logic [31:0]                       homing_offset_o,
  output logic [15:0]                       msg_timeout_o,
  // diagnostic events
  output logic                              diag_in_o,
  output logic                              diag_out_o,
  output logic                              fault_lamp_o
);
  import diag_record_pkg::*;

  localparam logic [6:0] TICK_LAST = 7'(`TICK_CYCLES - 1);

  logic [6:0]   presc_q;
  logic [31:0]  ticker_q;
  logic [3:0]   err_q;
  logic [3:0]   short_q;
  logic [31:0]  diag_ts_q;
  logic [7:0]   detail [4];
  logic [7:0]   rec_d;
  logic [7:0]   rec_data_q;
  logic         rec_valid_q;
  logic [7:0]   flags_now;
  logic [7:0]   flags_prev;
  logic [7:0]   flag_rise;
  logic [7:0]   flag_fall;
  logic         diag_in_q;
  logic         diag_out_q;
  obj_area_e    area;
  logic         hit;
  logic         wr_allowed;
  logic         any_state;
  logic [31:0]  obj_rd;
  acyc_status_e acyc_res;
  logic         acyc_wr_ok;
  logic         ack_q;
  acyc_status_e status_q;
  logic [31:0]  rdata_q;
  logic [15:0]  ctrl_word_q;
  logic [3:0]   out_req_q;
  logic [31:0]  homing_q;
  logic [15:0]  timeout_q;
  logic [15:0]  cyc_status_q;
  logic [3:0]   cyc_outs_q;

  // free-running microsecond ticker
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      presc_q  <= 7'h00;
      ticker_q <= 32'h0000_0000;
    end else if (ce_i) begin
      if (presc_q == TICK_LAST) begin
        presc_q  <= 7'h00;
        ticker_q <= ticker_q + 32'h0000_0001;
      end else begin
        presc_q <= presc_q + 7'h01;
      end
    end
  end

  // fault flags and events
  assign flags_now  = {short_i, out_err_i};
  assign flags_prev = {short_q, err_q};
  assign flag_rise  = flags_now & ~flags_prev;
  assign flag_fall  = ~flags_now & flags_prev;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      err_q      <= 4'h0;
      short_q    <= 4'h0;
      diag_in_q  <= 1'b0;
      diag_out_q <= 1'b0;
    end else if (ce_i) begin
      err_q      <= out_err_i;
      short_q    <= short_i;
      diag_in_q  <= |flag_rise;
      diag_out_q <= |flag_fall;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      diag_ts_q <= 32'h0000_0000;
    end else if (ce_i && |flag_rise) begin
      diag_ts_q <= ticker_q;
    end
  end

  assign diag_in_o    = diag_in_q;
  assign diag_out_o   = diag_out_q;
  assign fault_lamp_o = |flags_prev;

  // per-channel detail bytes, only the short bit is meaningful
  generate
    for (genvar ch = 0; ch < 4; ch++) begin : g_detail
      always_comb begin
        detail[ch] = 8'h00;
        detail[ch][`SHORT_BIT_POS] = short_q[ch];
      end
    end
  endgenerate

  // record byte mux; header bytes 0..3 and spare channels read zero
  always_comb begin
    rec_d = 8'h00;
    if (rec_addr_i == `REC_CHANNEL_KIND) begin
      rec_d = `CHANNEL_KIND_VAL & 8'h7F;
    end else if (rec_addr_i == `REC_DIAG_BITS) begin
      rec_d = `DIAG_BITS_VAL;
    end else if (rec_addr_i == `REC_CHANNEL_COUNT) begin
      rec_d = `CHANNEL_COUNT_VAL;
    end else if (rec_addr_i == `REC_ERR_SUMMARY) begin
      rec_d = {4'h0, err_q};
    end else if (rec_addr_i >= `REC_DETAIL_FIRST &&
                 rec_addr_i <= `REC_DETAIL_LAST) begin
      rec_d = detail[rec_addr_i[1:0]];
    end else if (rec_addr_i >= `REC_TS_FIRST &&
                 rec_addr_i <= `REC_TS_LAST) begin
      rec_d = diag_ts_q[8*rec_addr_i[1:0] +: 8];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rec_data_q  <= 8'h00;
      rec_valid_q <= 1'b0;
    end else if (ce_i) begin
      rec_valid_q <= rec_rd_i;
      if (rec_rd_i) begin
        rec_data_q <= rec_d;
      end
    end
  end

  assign rec_valid_o = rec_valid_q;
  assign rec_data_o  = rec_data_q;

  // dictionary decode by index and subindex
  always_comb begin
    area = AREA_NONE;
    if (acyc_index_i >= `AREA_SYS_LO && acyc_index_i <= `AREA_SYS_HI) begin
      area = AREA_SYSTEM;
    end else if (acyc_index_i >= `AREA_IO_LO &&
                 acyc_index_i <= `AREA_IO_HI) begin
      area = AREA_IO;
    end else if (acyc_index_i >= `AREA_AXIS_LO &&
                 acyc_index_i <= `AREA_AXIS_HI) begin
      area = AREA_AXIS;
    end
  end

  always_comb begin
    hit        = 1'b0;
    wr_allowed = 1'b0;
    any_state  = 1'b0;
    obj_rd     = 32'h0000_0000;
    case (acyc_index_i)
      `OBJ_SYSTEM: begin
        if (acyc_sub_i == 8'h00) begin
          hit    = (area == AREA_SYSTEM);
          obj_rd = `SYSTEM_SUBS;
        end else if (acyc_sub_i == 8'h01) begin
          hit        = (area == AREA_SYSTEM);
          wr_allowed = 1'b1;
          any_state  = 1'b1;
          obj_rd     = {16'h0000, timeout_q};
        end
      end
      `OBJ_DOUT: begin
        if (acyc_sub_i == 8'h00) begin
          hit    = (area == AREA_IO);
          obj_rd = `DOUT_SUBS;
        end else if (acyc_sub_i == 8'h01) begin
          hit        = (area == AREA_IO);
          wr_allowed = 1'b1;
          any_state  = 1'b1;
          obj_rd     = {28'h0000000, out_req_q};
        end else if (acyc_sub_i == 8'h02) begin
          hit    = (area == AREA_IO);
          obj_rd = {28'h0000000, out_actual_i};
        end
      end
      `OBJ_CONTROL: begin
        if (acyc_sub_i == 8'h00) begin
          hit    = (area == AREA_AXIS);
          obj_rd = `CONTROL_SUBS;
        end else if (acyc_sub_i == 8'h01) begin
          hit        = (area == AREA_AXIS);
          wr_allowed = 1'b1;
          any_state  = 1'b1;
          obj_rd     = {16'h0000, ctrl_word_q};
        end else if (acyc_sub_i == 8'h02) begin
          hit    = (area == AREA_AXIS);
          obj_rd = {16'h0000, status_word_i};
        end
      end
      `OBJ_HOMING: begin
        if (acyc_sub_i == 8'h00) begin
          hit    = (area == AREA_AXIS);
          obj_rd = `HOMING_SUBS;
        end else if (acyc_sub_i == 8'h01) begin
          hit        = (area == AREA_AXIS);
          wr_allowed = 1'b1;
          obj_rd     = homing_q;
        end
      end
      default: begin
        hit = 1'b0;
      end
    endcase
  end

  always_comb begin
    acyc_res = ACYC_OK;
    if (!hit) begin
      acyc_res = ACYC_NO_OBJECT;
    end else if (acyc_wr_i && !wr_allowed) begin
      acyc_res = ACYC_READ_ONLY;
    end else if (acyc_wr_i && !any_state && !drive_sod_i) begin
      acyc_res = ACYC_LOCKED;
    end
  end

  assign acyc_wr_ok = acyc_req_i && acyc_wr_i && (acyc_res == ACYC_OK);

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      ack_q    <= 1'b0;
      status_q <= ACYC_OK;
      rdata_q  <= 32'h0000_0000;
    end else if (ce_i) begin
      ack_q <= acyc_req_i;
      if (acyc_req_i) begin
        status_q <= acyc_res;
        rdata_q  <= acyc_wr_i ? 32'h0000_0000 : obj_rd;
      end
    end
  end

  assign acyc_ack_o    = ack_q;
  assign acyc_status_o = status_q;
  assign acyc_rdata_o  = rdata_q;

  // mapped objects: a cyclic exchange always wins over the acyclic write
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      ctrl_word_q <= `CTRL_WORD_RST;
      out_req_q   <= `OUT_REQ_RST;
    end else if (ce_i) begin
      if (cyc_strobe_i) begin
        ctrl_word_q <= cyc_ctrl_word_i;
        out_req_q   <= cyc_out_req_i;
      end else if (acyc_wr_ok && acyc_index_i == `OBJ_CONTROL) begin
        ctrl_word_q <= acyc_wdata_i[15:0];
      end else if (acyc_wr_ok && acyc_index_i == `OBJ_DOUT) begin
        out_req_q <= acyc_wdata_i[3:0];
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      homing_q  <= `HOMING_RST;
      timeout_q <= `MSG_TIMEOUT_RST;
    end else if (ce_i && acyc_wr_ok) begin
      if (acyc_index_i == `OBJ_HOMING) begin
        homing_q <= acyc_wdata_i;
      end
      if (acyc_index_i == `OBJ_SYSTEM) begin
        timeout_q <= acyc_wdata_i[15:0];
      end
    end
  end

  // input image, fixed layout
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      cyc_status_q <= 16'h0000;
      cyc_outs_q   <= 4'h0;
    end else if (ce_i && cyc_strobe_i) begin
      cyc_status_q <= status_word_i;
      cyc_outs_q   <= out_actual_i;
    end
  end

  assign cyc_in_status_o = cyc_status_q;
  assign cyc_in_outs_o   = cyc_outs_q;
  assign ctrl_word_o     = ctrl_word_q;
  assign out_req_o       = out_req_q;
  assign homing_offset_o = homing_q;
  assign msg_timeout_o   = timeout_q;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  chk_kind_byte: assert property (
    rec_rd_i && ce_i && rec_addr_i == `REC_CHANNEL_KIND |=>
      rec_data_o == 8'h72 && !rec_data_o[7])
    else $error("channel kind byte wrong");
  chk_bits_count: assert property (
    rec_rd_i && ce_i && rec_addr_i == `REC_DIAG_BITS |=>
      rec_data_o == 8'h08)
    else $error("diag bit count byte wrong");
  chk_count_byte: assert property (
    rec_rd_i && ce_i && rec_addr_i == `REC_CHANNEL_COUNT |=>
      rec_data_o == 8'h04)
    else $error("channel count byte wrong");
  chk_err_summary: assert property (
    rec_rd_i && ce_i && rec_addr_i == `REC_ERR_SUMMARY |=>
      rec_data_o == {4'h0, $past(err_q)})
    else $error("error summary byte wrong");
  chk_detail_short: assert property (
    rec_rd_i && ce_i && rec_addr_i == `REC_DETAIL_FIRST |=>
      rec_data_o == {4'h0, $past(short_q[0]), 3'h0})
    else $error("detail byte wrong");
  chk_spare_zero: assert property (
    rec_rd_i && ce_i && rec_addr_i == 5'h0E |=> rec_data_o == 8'h00)
    else $error("reserved byte not zero");
  chk_ts_capture: assert property (
    ce_i && |flag_rise |=> diag_ts_q == $past(ticker_q))
    else $error("timestamp not captured");
  chk_ack_every: assert property (
    acyc_req_i && ce_i |=> acyc_ack_o)
    else $error("acyclic access not acknowledged");
  chk_area_miss: assert property (
    acyc_req_i && ce_i && acyc_index_i > `AREA_AXIS_HI |=>
      acyc_status_o == ACYC_NO_OBJECT)
    else $error("out of area index accepted");
  chk_sub_zero: assert property (
    acyc_req_i && ce_i && !acyc_wr_i && acyc_index_i == `OBJ_CONTROL &&
      acyc_sub_i == 8'h00 |=> acyc_rdata_o == 32'h0000_0002)
    else $error("subindex zero count wrong");
  chk_cyclic_wins: assert property (
    cyc_strobe_i && ce_i |=> ctrl_word_o == $past(cyc_ctrl_word_i) &&
      out_req_o == $past(cyc_out_req_i))
    else $error("cyclic value did not overwrite");
  chk_state_lock: assert property (
    acyc_req_i && acyc_wr_i && ce_i && !drive_sod_i &&
      acyc_index_i == `OBJ_HOMING && acyc_sub_i == 8'h01 |=>
      acyc_status_o == ACYC_LOCKED && $stable(homing_offset_o))
    else $error("write accepted outside disabled state");
  // a pulse frozen by a low enable is not a fresh rise
  chk_lamp_event: assert property (
    diag_in_o && $past(ce_i) |->
      fault_lamp_o && $past(flags_prev) != flags_prev)
    else $error("incoming event without lamp");

  cov_incoming: cover property (diag_in_o ##[1:50] diag_out_o);
  cov_acyc_write: cover property (
    acyc_req_i && acyc_wr_i && ce_i && acyc_res == ACYC_OK);
  cov_overwrite: cover property (
    acyc_wr_ok && ce_i && acyc_index_i == `OBJ_CONTROL ##1 cyc_strobe_i);
endmodule

// ==== coupler_model.sv ====
`timescale 1ns/1ps

module coupler_model (
  // clock
  input  wire logic                          ref_clk_i,
  // record read
  output logic                               rec_rd_o,
  output logic [4:0]                         rec_addr_o,
  input  wire logic                          rec_valid_i,
  input  wire logic [7:0]                    rec_data_i,
  // acyclic channel
  output logic                               acyc_req_o,
  output logic                               acyc_wr_o,
  output logic [15:0]                        acyc_index_o,
  output logic [7:0]                         acyc_sub_o,
  output logic [31:0]                        acyc_wdata_o,
  input  wire logic                          acyc_ack_i,
  input  wire diag_record_pkg::acyc_status_e acyc_status_i,
  input  wire logic [31:0]                   acyc_rdata_i,
  // cyclic io image
  output logic                               cyc_strobe_o,
  output logic [15:0]                        cyc_ctrl_word_o,
  output logic [3:0]                         cyc_out_req_o
);
  import diag_record_pkg::*;

  initial begin
    {rec_rd_o, rec_addr_o, acyc_req_o, acyc_wr_o} = '0;
    {acyc_index_o, acyc_sub_o, acyc_wdata_o} = '0;
    {cyc_strobe_o, cyc_ctrl_word_o, cyc_out_req_o} = '0;
  end

  // answers are registered, so they stand at the next falling edge
  task automatic rec_read(input logic [4:0] addr, output logic vld,
                          output logic [7:0] data);
    @(negedge ref_clk_i);
    rec_rd_o = 1'b1;
    rec_addr_o = addr;
    @(negedge ref_clk_i);
    vld = rec_valid_i;
    data = rec_data_i;
    rec_rd_o = 1'b0;
    rec_addr_o = ~addr;
  endtask

  // one object picked by its index and subindex pair
  task automatic acyc(input logic wr, input logic [15:0] ix,
                      input logic [7:0] sb, input logic [31:0] wd,
                      output logic ack, output acyc_status_e st,
                      output logic [31:0] rd);
    @(negedge ref_clk_i);
    acyc_req_o = 1'b1;
    acyc_wr_o = wr;
    acyc_index_o = ix;
    acyc_sub_o = sb;
    acyc_wdata_o = wd;
    @(negedge ref_clk_i);
    ack = acyc_ack_i;
    st = acyc_status_i;
    rd = acyc_rdata_i;
    acyc_req_o = 1'b0;
    // released qualifiers flip so stale values cannot pass
    acyc_wr_o = ~wr;
    acyc_index_o = ~ix;
    acyc_sub_o = ~sb;
    acyc_wdata_o = ~wd;
  endtask

  task automatic cyc(input logic [15:0] ctrl, input logic [3:0] req);
    @(negedge ref_clk_i);
    cyc_strobe_o = 1'b1;
    cyc_ctrl_word_o = ctrl;
    cyc_out_req_o = req;
    @(negedge ref_clk_i);
    cyc_strobe_o = 1'b0;
    cyc_ctrl_word_o = ~ctrl;
    cyc_out_req_o = ~req;
  endtask
endmodule

// ==== diag_record_and_object_access_tb.sv ====
`timescale 1ns/1ps
`include "diag_record_consts.svh"

module diag_record_and_object_access_tb;
  import diag_record_pkg::*;

  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b0;
  logic [3:0] out_err_i = '0, short_i = '0, out_actual_i = 4'h9;
  logic [15:0] status_word_i = 16'h5A3C;
  logic drive_sod_i = 1'b0;
  logic rec_rd_i, rec_valid_o, acyc_req_i, acyc_wr_i, acyc_ack_o;
  logic cyc_strobe_i, diag_in_o, diag_out_o, fault_lamp_o;
  logic [4:0] rec_addr_i;
  logic [7:0] rec_data_o, acyc_sub_i;
  logic [15:0] acyc_index_i, cyc_ctrl_word_i, cyc_in_status_o;
  logic [15:0] ctrl_word_o, msg_timeout_o;
  logic [31:0] acyc_wdata_i, acyc_rdata_o, homing_offset_o, ts;
  logic [3:0] cyc_out_req_i, cyc_in_outs_o, out_req_o;
  acyc_status_e acyc_status_o;
  int num_errors = 0, checked = 0, cycles = 0, rel = 0, k;
  logic vld;
  logic [7:0] d;
  logic [15:0] obj_ix [4] = '{16'h6100, 16'h7200, 16'h8100, 16'h8300};
  logic [31:0] obj_n [4] = '{32'h1, 32'h2, 32'h2, 32'h1};

  diag_record_and_object_access dut_u (.ref_clk_i, .rst_i, .ce_i,
    .out_err_i, .short_i, .rec_rd_i, .rec_addr_i, .rec_valid_o,
    .rec_data_o, .acyc_req_i, .acyc_wr_i, .acyc_index_i, .acyc_sub_i,
    .acyc_wdata_i, .acyc_ack_o, .acyc_status_o, .acyc_rdata_o,
    .cyc_strobe_i, .cyc_ctrl_word_i, .cyc_out_req_i, .cyc_in_status_o,
    .cyc_in_outs_o, .status_word_i, .out_actual_i, .drive_sod_i,
    .ctrl_word_o, .out_req_o, .homing_offset_o, .msg_timeout_o,
    .diag_in_o, .diag_out_o, .fault_lamp_o);

  coupler_model cpl_u (.ref_clk_i, .rec_rd_o(rec_rd_i),
    .rec_addr_o(rec_addr_i), .rec_valid_i(rec_valid_o),
    .rec_data_i(rec_data_o), .acyc_req_o(acyc_req_i),
    .acyc_wr_o(acyc_wr_i), .acyc_index_o(acyc_index_i),
    .acyc_sub_o(acyc_sub_i), .acyc_wdata_o(acyc_wdata_i),
    .acyc_ack_i(acyc_ack_o), .acyc_status_i(acyc_status_o),
    .acyc_rdata_i(acyc_rdata_o), .cyc_strobe_o(cyc_strobe_i),
    .cyc_ctrl_word_o(cyc_ctrl_word_i), .cyc_out_req_o(cyc_out_req_i));

  always #4 ref_clk_i = ~ref_clk_i;

  task automatic summarize();
    if (num_errors == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  always @(posedge ref_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors = num_errors + 1;
      summarize();
    end
  end

  task automatic check(input string name, input logic [31:0] seen, exp);
    checked = checked + 1;
    if (seen !== exp) begin
      num_errors = num_errors + 1;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  function automatic logic [7:0] exp_rec(input logic [4:0] a,
                                         input logic [3:0] e, s);
    case (a)
      `REC_CHANNEL_KIND:  return 8'h72;
      `REC_DIAG_BITS:     return 8'h08;
      `REC_CHANNEL_COUNT: return 8'h04;
      `REC_ERR_SUMMARY:   return {4'h0, e};
      5'h08, 5'h09, 5'h0A, 5'h0B: return {4'h0, s[a[1:0]], 3'b000};
      default:            return 8'h00;
    endcase
  endfunction

  // whole record below the timestamp, against the current fault inputs
  task automatic rec_sweep();
    for (int a = 0; a < 16; a++) begin
      cpl_u.rec_read(a[4:0], vld, d);
      check("rec_valid", {31'b0, vld}, 32'h1);
      check("rec_byte", {24'b0, d}, {24'b0, exp_rec(a[4:0], out_err_i,
            short_i)});
    end
  endtask

  task automatic ac(input logic wr, input logic [15:0] ix,
                    input logic [7:0] sb, input logic [31:0] wd,
                    input acyc_status_e es, input logic [31:0] erd);
    logic ack;
    acyc_status_e st;
    logic [31:0] rd;
    cpl_u.acyc(wr, ix, sb, wd, ack, st, rd);
    check("acyc_ack", {31'b0, ack}, 32'h1);
    check("acyc_status", {30'b0, st}, {30'b0, es});
    check("acyc_rdata", rd, erd);
  endtask

  task automatic fault_step(input logic [3:0] e, s, input logic in,
                            out, lamp);
    @(negedge ref_clk_i);
    out_err_i = e;
    short_i = s;
    @(posedge ref_clk_i);
    #1;
    check("diag_events", {29'b0, diag_in_o, diag_out_o, fault_lamp_o},
          {29'b0, in, out, lamp});
    @(posedge ref_clk_i);
    #1;
    check("event_pulse", {30'b0, diag_in_o, diag_out_o}, 32'h0);
  endtask

  initial begin
    repeat (3) @(negedge ref_clk_i);
    rst_i = 1'b0;
    ce_i = 1'b1;
    rel = cycles;
    check("reset_ctrl", {ctrl_word_o, msg_timeout_o}, 32'h0);
    check("reset_homing", homing_offset_o, 32'h0);
    check("reset_misc", {27'b0, out_req_o, fault_lamp_o}, 32'h0);
    rec_sweep();
    repeat (600) @(negedge ref_clk_i);
    k = cycles - rel;
    fault_step(4'hA, 4'h5, 1'b1, 1'b0, 1'b1);
    rec_sweep();
    for (int i = 0; i < 4; i++) begin
      cpl_u.rec_read(`REC_TS_FIRST + i[4:0], vld, d);
      ts[8*i +: 8] = d;
    end
    // prescaler restarts at reset; the rise is taken two edges after k
    check("timestamp", ts, (k + 1) / (`TICK_NS / `CLK_NS));
    fault_step(4'h0, 4'h5, 1'b0, 1'b1, 1'b1);
    fault_step(4'h0, 4'h0, 1'b0, 1'b1, 1'b0);
    for (int i = 0; i < 4; i++) begin
      ac(1'b0, obj_ix[i], 8'h00, 32'h0, ACYC_OK, obj_n[i]);
    end
    ac(1'b0, 16'h9000, 8'h00, 32'h0, ACYC_NO_OBJECT, 32'h0);
    ac(1'b0, 16'h6100, 8'h05, 32'h0, ACYC_NO_OBJECT, 32'h0);
    ac(1'b0, 16'h8100, 8'h02, 32'h0, ACYC_OK, 32'h5A3C);
    ac(1'b0, 16'h7200, 8'h02, 32'h0, ACYC_OK, 32'h9);
    ac(1'b1, 16'h8100, 8'h00, 32'h7, ACYC_READ_ONLY, 32'h0);
    ac(1'b1, 16'h7200, 8'h02, 32'h3, ACYC_READ_ONLY, 32'h0);
    ac(1'b1, 16'h8300, 8'h01, 32'hDEADBEEF, ACYC_LOCKED, 32'h0);
    check("homing_locked", homing_offset_o, 32'h0);
    ac(1'b1, 16'h6100, 8'h01, 32'h0123, ACYC_OK, 32'h0);
    check("msg_timeout", {16'b0, msg_timeout_o}, 32'h0123);
    drive_sod_i = 1'b1;
    ac(1'b1, 16'h8300, 8'h01, 32'hDEADBEEF, ACYC_OK, 32'h0);
    check("homing", homing_offset_o, 32'hDEADBEEF);
    ac(1'b0, 16'h8300, 8'h01, 32'h0, ACYC_OK, 32'hDEADBEEF);
    drive_sod_i = 1'b0;
    cpl_u.cyc(16'h1234, 4'h5);
    check("cyc_out", {ctrl_word_o, 12'b0, out_req_o},
          32'h1234_0005);
    check("cyc_in", {cyc_in_status_o, 12'b0, cyc_in_outs_o},
          32'h5A3C_0009);
    ac(1'b1, 16'h7200, 8'h01, 32'h3, ACYC_OK, 32'h0);
    ac(1'b1, 16'h8100, 8'h01, 32'hABCD, ACYC_OK, 32'h0);
    check("acyc_mapped", {ctrl_word_o, 12'b0, out_req_o},
          32'hABCD_0003);
    cpl_u.cyc(16'h1234, 4'h5);
    check("cyc_overwrite", {ctrl_word_o, 12'b0, out_req_o},
          32'h1234_0005);
    @(negedge ref_clk_i);
    ce_i = 1'b0;
    cpl_u.rec_read(`REC_CHANNEL_KIND, vld, d);
    check("frozen_read", {31'b0, vld}, 32'h0);
    ce_i = 1'b1;
    @(negedge ref_clk_i);
    rst_i = 1'b1;
    @(negedge ref_clk_i);
    rst_i = 1'b0;
    check("rerst_out", {ctrl_word_o, 12'b0, out_req_o}, 32'h0);
    check("rerst_homing", homing_offset_o, 32'h0);
    summarize();
  end
endmodule
